// File: core/pimt_defs.vh
// Register map, field positions and command codes of the priority interrupt core
`ifndef PIMT_DEFS_VH
`define PIMT_DEFS_VH

`define PIMT_ADDR_MASK 8'h00
`define PIMT_ADDR_CTRL 8'h04
`define PIMT_ADDR_CMD 8'h08
`define PIMT_ADDR_STATUS 8'h0c

`define PIMT_MASK_RESET 8'hff
`define PIMT_CTRL_EDGE_BIT 0
`define PIMT_CTRL_AUTO_EOI_BIT 1
`define PIMT_CTRL_EXCL_BIT 2

`define PIMT_CMD_NONSPEC 3'h1
`define PIMT_CMD_SPEC 3'h3
`define PIMT_CMD_ROT_SPEC 3'h7
`define PIMT_CMD_SET_PRIO 3'h6
`define PIMT_CMD_EXCL_SET 3'h4
`define PIMT_CMD_EXCL_CLR 3'h5
`define PIMT_CMD_LEVEL_LSB 0
`define PIMT_CMD_OP_LSB 4

`define PIMT_DEFAULT_LEVEL 3'h7
`define PIMT_LOWEST_RESET 3'h7

`define PIMT_RESP_OKAY 2'h0
`define PIMT_RESP_SLVERR 2'h2

`endif

// File: core/pimt_core.v
// Eight-input priority interrupt core with mask, rotation and trigger modes
//
// Function
// - Rotate-on-specific end command clears named in-service bit and makes it lowest
// - Eight-bit mask register; bit n set disables request input n
// - Mask gates only latch output; masked inputs still set and keep latch bits
// - Unmasking a latched, still-active request raises an interrupt by priority
// - Fully nested mode blocks requests below highest level in service
// - Exclude-masked mode lets every unmasked level interrupt until explicitly cleared
// - Exclude-masked mode blocks every masked level, not just one
// - In exclude-masked mode, non-specific end skips masked in-service bits
// - Software can never set an in-service bit; only acknowledge does
// - Level or edge sensing comes from setup and applies to all inputs
// - Level mode: high input requests; re-interrupts after end if still high
// - Request dropped before first acknowledge rises: respond as level 7
// - Edge mode recognizes only low-to-high transitions of a request input
// - Edge mode disarms latch on acknowledge until input low; level always armed
// - Automatic end mode performs the end when the acknowledge sequence finishes
// - After rotation, priorities run circularly from the level after the lowest
// - Non-specific end clears the highest-priority in-service bit set
// - Priorities resolve every clock, so command writes count as well as requests and acknowledges
`timescale 1ns/1ps
`include "pimt_defs.vh"

module pimt_core (
    // Clock and reset
    input wire clock_i,
    input wire reset_n_i,
    // Request inputs and processor handshake
    input wire [7:0] request_inputs_i,
    input wire acknowledge_pulse_i,
    output reg interrupt_o,
    output reg [2:0] ack_level_o,
    output reg ack_level_valid_o,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    reg [7:0] interrupt_mask_reg;
    reg [7:0] pending_request_latch_reg;
    reg [7:0] in_service_bits_reg;
    reg [7:0] armed_reg;
    reg [7:0] req_prev_reg;
    reg [2:0] lowest_reg;
    reg edge_mode_reg;
    reg auto_eoi_reg;
    reg exclude_masked_mode_reg;
    reg [1:0] ack_count_reg;
    reg [2:0] frozen_level_reg;
    reg ack_prev_reg;
    reg aw_held_reg;
    reg w_held_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    // Priority rank of each level: 0 is highest, the level after the lowest comes first
    wire [2:0] rank [0:7];
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_rank
            wire [31:0] level_full = g;
            assign rank[g] = level_full[2:0] - lowest_reg - 3'h1;
        end
    endgenerate

    // Mask gates only what leaves the latch; a masked line still sets and holds its bit
    wire [7:0] req_visible = pending_request_latch_reg & ~interrupt_mask_reg;
    // Masked in-service bits drop out of ranking and of non-specific end in this mode
    wire [7:0] isr_visible = exclude_masked_mode_reg ?
        (in_service_bits_reg & ~interrupt_mask_reg) : in_service_bits_reg;

    // Highest-priority set bit of a vector, walking the circular order
    // Walking from the lowest level upwards lets the last hit be the winner
    function [3:0] pimt_top;
        input [7:0] vec;
        input [2:0] low;
        integer k;
        reg [2:0] lvl;
        begin
            pimt_top = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                lvl = low + k[2:0] + 3'h1;
                if (vec[lvl])
                    pimt_top = {1'b1, lvl};
            end
        end
    endfunction

    wire [3:0] top_req = pimt_top(req_visible, lowest_reg);
    wire [3:0] top_isr = pimt_top(isr_visible, lowest_reg);
    // Equal rank loses, so a level in service never re-interrupts itself when nested
    wire req_wins = top_req[3] &&
        (exclude_masked_mode_reg || !top_isr[3] ||
         rank[top_req[2:0]] < rank[top_isr[2:0]]);

    // Raw input seen as a request: level, or a rising edge on an armed latch
    wire [7:0] req_set = edge_mode_reg ?
        (request_inputs_i & ~req_prev_reg & armed_reg) : request_inputs_i;
    // Latch bits drop with the line in both modes: a request withdrawn before the
    // first acknowledge is no longer visible, so the sequence falls back to level 7
    wire [7:0] latch_keep = pending_request_latch_reg & request_inputs_i;

    // Pulses are counted on falling edges; a cut train waits for its missing falls
    wire ack_fall = ack_prev_reg && !acknowledge_pulse_i;
    wire ack_rise = !ack_prev_reg && acknowledge_pulse_i;
    wire first_done = ack_fall && ack_count_reg == 2'h0;
    wire last_done = ack_fall && ack_count_reg == 2'h2;

    // Bus write decode once both address and data are held
    // Only byte lane 0 carries register content; the other lanes are ignored
    wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [7:0] wr_byte0 = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
    wire wr_mask = wr_go && aw_addr_reg == `PIMT_ADDR_MASK && w_strb_reg[0];
    wire wr_ctrl = wr_go && aw_addr_reg == `PIMT_ADDR_CTRL && w_strb_reg[0];
    wire wr_cmd = wr_go && aw_addr_reg == `PIMT_ADDR_CMD && w_strb_reg[0];
    wire wr_known = aw_addr_reg == `PIMT_ADDR_MASK || aw_addr_reg == `PIMT_ADDR_CTRL ||
        aw_addr_reg == `PIMT_ADDR_CMD;
    wire [2:0] cmd_op = wr_byte0[`PIMT_CMD_OP_LSB +: 3];
    wire [2:0] cmd_lvl = wr_byte0[`PIMT_CMD_LEVEL_LSB +: 3];

    reg [7:0] isr_next;
    reg [7:0] irr_next;
    reg [7:0] armed_next;
    reg [2:0] lowest_next;
    reg [2:0] level_pick;
    // Later statements override earlier ones: commands clear first and the acknowledge
    // set comes last, so an acknowledge and a clear of one level leave the bit set
    always @* begin
        isr_next = in_service_bits_reg;
        irr_next = latch_keep | req_set;
        armed_next = armed_reg | (edge_mode_reg ? ~request_inputs_i : 8'hff);
        lowest_next = lowest_reg;
        level_pick = frozen_level_reg;
        // Automatic end behaves as a non-specific end at the last pulse
        // and uses the same visible ranking, so exclude-masked bits survive it too
        if (last_done && auto_eoi_reg && top_isr[3])
            isr_next[top_isr[2:0]] = 1'b0;
        if (wr_cmd) begin
            case (cmd_op)
                `PIMT_CMD_NONSPEC: begin
                    if (top_isr[3])
                        isr_next[top_isr[2:0]] = 1'b0;
                end
                `PIMT_CMD_SPEC: begin
                    isr_next[cmd_lvl] = 1'b0;
                end
                `PIMT_CMD_ROT_SPEC: begin
                    isr_next[cmd_lvl] = 1'b0;
                    lowest_next = cmd_lvl;
                end
                `PIMT_CMD_SET_PRIO: begin
                    lowest_next = cmd_lvl;
                end
                default: begin
                end
            endcase
        end
        // Level is chosen at the first acknowledge, with the request still visible
        if (ack_rise && ack_count_reg == 2'h0) begin
            level_pick = req_wins ? top_req[2:0] : `PIMT_DEFAULT_LEVEL;
            isr_next[level_pick] = 1'b1;
            irr_next[level_pick] = 1'b0;
            if (edge_mode_reg)
                armed_next[level_pick] = 1'b0;
        end
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            interrupt_mask_reg <= `PIMT_MASK_RESET;
            pending_request_latch_reg <= 8'h00;
            in_service_bits_reg <= 8'h00;
            armed_reg <= 8'hff;
            req_prev_reg <= 8'h00;
            lowest_reg <= `PIMT_LOWEST_RESET;
            edge_mode_reg <= 1'b0;
            auto_eoi_reg <= 1'b0;
            exclude_masked_mode_reg <= 1'b0;
            ack_count_reg <= 2'h0;
            frozen_level_reg <= 3'h0;
            ack_prev_reg <= 1'b0;
            interrupt_o <= 1'b0;
            ack_level_o <= 3'h0;
            ack_level_valid_o <= 1'b0;
        end else begin
            req_prev_reg <= request_inputs_i;
            ack_prev_reg <= acknowledge_pulse_i;
            in_service_bits_reg <= isr_next;
            pending_request_latch_reg <= irr_next;
            armed_reg <= armed_next;
            lowest_reg <= lowest_next;
            frozen_level_reg <= level_pick;
            interrupt_o <= req_wins;
            if (wr_mask)
                interrupt_mask_reg <= wr_byte0;
            // One mode bit covers every input; the exclude bit changes only by command
            if (wr_ctrl) begin
                edge_mode_reg <= wr_byte0[`PIMT_CTRL_EDGE_BIT];
                auto_eoi_reg <= wr_byte0[`PIMT_CTRL_AUTO_EOI_BIT];
            end
            if (wr_cmd && cmd_op == `PIMT_CMD_EXCL_SET)
                exclude_masked_mode_reg <= 1'b1;
            else if (wr_cmd && cmd_op == `PIMT_CMD_EXCL_CLR)
                exclude_masked_mode_reg <= 1'b0;
            // Three pulses form one sequence; the level is reported after the first
            if (ack_fall)
                ack_count_reg <= (ack_count_reg == 2'h2) ? 2'h0 : ack_count_reg + 2'h1;
            ack_level_valid_o <= first_done;
            if (first_done)
                ack_level_o <= frozen_level_reg;
        end
    end

    // AXI4-Lite write path: address and data accepted independently
    // A held beat blocks a new one until the response is raised; the next write waits for it to be taken
    // Unmapped offsets answer SLVERR and change nothing
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PIMT_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `PIMT_RESP_OKAY : `PIMT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path; registers are read without side effects
    // The command register is write only, so a read of it answers SLVERR
    wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PIMT_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PIMT_RESP_OKAY;
                case (rd_addr)
                    `PIMT_ADDR_MASK: s_axi_rdata <= {24'h000000, interrupt_mask_reg};
                    `PIMT_ADDR_CTRL: s_axi_rdata <= {29'h00000000, exclude_masked_mode_reg,
                        auto_eoi_reg, edge_mode_reg};
                    `PIMT_ADDR_STATUS: s_axi_rdata <= {13'h0000, lowest_reg,
                        in_service_bits_reg, pending_request_latch_reg};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `PIMT_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pimt_core

// File: verif/pimt_core_props.sv
// Bus handshake and acknowledge timing checks for the priority interrupt core
`timescale 1ns/1ps
module pimt_core_props (
    // Clock and reset
    input wire clock_i,
    input wire reset_n_i,
    // Acknowledge link
    input wire acknowledge_pulse_i,
    input wire ack_level_valid_o,
    // Register bus
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_bwait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_rwait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready long");
    AST_WREADY_PULSE: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready long");
    AST_ARREADY_CAUSE: assert property (s_axi_arready |-> $past(s_axi_arvalid))
        else $error("arready without arvalid");
    AST_R_FOLLOWS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
    AST_R_HOLD: assert property (s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_B_HOLD: assert property (s_bwait |=> s_axi_bvalid) else $error("write answer dropped");
    AST_VALID_PULSE: assert property (ack_level_valid_o |=> !ack_level_valid_o)
        else $error("grant valid long");
    // Grant follows a falling acknowledge pulse by one or two samples
    AST_VALID_CAUSE: assert property (ack_level_valid_o |->
        $past(acknowledge_pulse_i, 2) && !$past(acknowledge_pulse_i, 1) ||
        $past(acknowledge_pulse_i, 3) && !$past(acknowledge_pulse_i, 2))
        else $error("grant valid without pulse end");
endmodule // pimt_core_props

bind pimt_core pimt_core_props u_props (.*);

// File: verif/pimt_cpu_model.sv
// Processor side model issuing three-pulse acknowledge sequences
`timescale 1ns/1ps
module pimt_cpu_model (
    // Clock
    input wire clock_i,
    // Acknowledge towards the core
    output reg ack_pulse_o
);
    initial ack_pulse_o = 1'b0;
    // Gap stretches every phase, so slow processors are exercised too
    task seq(input integer gap);
        integer p;
        begin
            for (p = 0; p < 6; p = p + 1) begin
                @(posedge clock_i);
                ack_pulse_o <= ~p[0];
                repeat (gap) @(posedge clock_i);
            end
        end
    endtask
endmodule // pimt_cpu_model

// File: verif/pimt_core_tb.sv
// Self-checking bench for the priority interrupt core
`timescale 1ns/1ps
`include "pimt_defs.vh"
module pimt_core_tb;
    reg clock_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg [7:0] request_inputs_i = 8'h00;
    wire acknowledge_pulse_i, interrupt_o, ack_level_valid_o;
    wire [2:0] ack_level_o;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer bad_count = 0, checked = 0, seed = 32'h284b, k, r, l, w;
    integer vcount = 0;
    pimt_core DUT (.*);
    pimt_cpu_model u_cpu (.clock_i(clock_i), .ack_pulse_o(acknowledge_pulse_i));
    // Grant pulses are counted where they are settled, between rising edges
    always @(negedge clock_i) if (ack_level_valid_o === 1'b1) vcount <= vcount + 1;
    initial forever #12.5 clock_i = ~clock_i;
    task close_out;
        begin
            $display("checked %0d mismatches %0d", checked, bad_count);
            if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] s);
        begin
            checked = checked + 1;
            if (s !== e) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    task tmo;
        begin
            bad_count = bad_count + 1;
            close_out;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        integer n;
        reg ha, hw, hb;
        reg [1:0] bs;
        begin
            @(posedge clock_i);
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            hb = 1'b0;
            for (n = 0; n < 40 && !hb; n = n + 1) begin
                @(negedge clock_i);
                ha = s_axi_awvalid && s_axi_awready;
                hw = s_axi_wvalid && s_axi_wready;
                hb = s_axi_bvalid;
                bs = s_axi_bresp;
                @(posedge clock_i);
                if (ha) s_axi_awvalid <= 1'b0;
                if (hw) s_axi_wvalid <= 1'b0;
                if (hb) s_axi_bready <= 1'b0;
            end
            if (!hb) tmo;
            chk("bresp", (a == `PIMT_ADDR_MASK || a == `PIMT_ADDR_CTRL || a == `PIMT_ADDR_CMD) ?
                `PIMT_RESP_OKAY : `PIMT_RESP_SLVERR, bs);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e, input [1:0] re);
        integer n;
        reg ha, hd;
        reg [31:0] d;
        reg [1:0] rs;
        begin
            @(posedge clock_i);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            hd = 1'b0;
            for (n = 0; n < 40 && !hd; n = n + 1) begin
                @(negedge clock_i);
                ha = s_axi_arvalid && s_axi_arready;
                hd = s_axi_rvalid;
                d = s_axi_rdata;
                rs = s_axi_rresp;
                @(posedge clock_i);
                if (ha) s_axi_arvalid <= 1'b0;
                if (hd) s_axi_rready <= 1'b0;
            end
            if (!hd) tmo;
            chk("rdata", e, d);
            chk("rresp", re, rs);
        end
    endtask
    // Interrupt output lags by a cycle, so let it settle before looking
    task ci(input e);
        begin
            repeat (3) @(negedge clock_i);
            chk("interrupt", e, interrupt_o);
        end
    endtask
    task ack(input [2:0] e, input integer g);
        integer v;
        begin
            v = vcount;
            u_cpu.seq(g);
            @(negedge clock_i);
            chk("ack_level", e, ack_level_o);
            chk("grant_pulses", v + 1, vcount);
        end
    endtask
    function [31:0] stat(input [7:0] p, input [7:0] s, input [2:0] lo);
        stat = {13'h0, lo, s, p};
    endfunction
    function [2:0] win(input [7:0] q, input [2:0] lo);
        integer i;
        begin
            win = 3'h7;
            for (i = 8; i > 0; i = i - 1) if (q[lo + i[2:0]]) win = lo + i[2:0];
        end
    endfunction
    initial begin
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1'b1;
        rd(`PIMT_ADDR_MASK, 32'hff, `PIMT_RESP_OKAY);
        rd(`PIMT_ADDR_STATUS, stat(0, 0, 7), `PIMT_RESP_OKAY);
        rd(8'h10, 0, `PIMT_RESP_SLVERR);
        rd(`PIMT_ADDR_CMD, 0, `PIMT_RESP_SLVERR);
        wr(8'h10, 8'h00);
        $display("test reset done");
        request_inputs_i <= 8'h08;
        ci(0);
        rd(`PIMT_ADDR_STATUS, stat(8'h08, 0, 7), `PIMT_RESP_OKAY);
        wr(`PIMT_ADDR_MASK, 8'hf7);
        ci(1);
        ack(3, 0);
        ci(0);
        request_inputs_i <= 8'h18;
        ci(0);
        $display("test masking done");
        wr(`PIMT_ADDR_CMD, 8'h40);
        ci(1);
        rd(`PIMT_ADDR_CTRL, 32'h4, `PIMT_RESP_OKAY);
        wr(`PIMT_ADDR_MASK, 8'h18);
        ci(0);
        wr(`PIMT_ADDR_CMD, 8'h10);
        rd(`PIMT_ADDR_STATUS, stat(8'h18, 8'h08, 7), `PIMT_RESP_OKAY);
        wr(`PIMT_ADDR_CMD, 8'h33);
        wr(`PIMT_ADDR_CMD, 8'h50);
        rd(`PIMT_ADDR_STATUS, stat(8'h18, 0, 7), `PIMT_RESP_OKAY);
        wr(`PIMT_ADDR_MASK, 8'h00);
        ci(1);
        request_inputs_i <= 8'h00;
        ci(0);
        wr(`PIMT_ADDR_CMD, 8'h62);
        ci(0);
        ack(7, 0);
        rd(`PIMT_ADDR_STATUS, stat(0, 8'h80, 2), `PIMT_RESP_OKAY);
        wr(`PIMT_ADDR_CMD, 8'h77);
        rd(`PIMT_ADDR_STATUS, stat(0, 0, 7), `PIMT_RESP_OKAY);
        $display("test exclude and rotate done");
        wr(`PIMT_ADDR_CTRL, 8'h01);
        request_inputs_i <= 8'h04;
        ci(1);
        ack(2, 1);
        wr(`PIMT_ADDR_CMD, 8'h32);
        ci(0);
        request_inputs_i <= 8'h00;
        ci(0);
        request_inputs_i <= 8'h04;
        ci(1);
        ack(2, 0);
        wr(`PIMT_ADDR_CMD, 8'h32);
        request_inputs_i <= 8'h20;
        ci(1);
        request_inputs_i <= 8'h00;
        ci(0);
        ack(7, 0);
        wr(`PIMT_ADDR_CMD, 8'h37);
        wr(`PIMT_ADDR_CTRL, 8'h02);
        request_inputs_i <= 8'h02;
        ack(1, 2);
        rd(`PIMT_ADDR_STATUS, stat(8'h02, 0, 7), `PIMT_RESP_OKAY);
        ci(1);
        $display("test triggering done");
        wr(`PIMT_ADDR_CTRL, 8'h00);
        request_inputs_i <= 8'h00;
        for (k = 0; k < 8; k = k + 1) begin
            l = $random(seed);
            r = $random(seed);
            w = $random(seed);
            if (r[7:0] == 8'h00) r = 1;
            wr(`PIMT_ADDR_CMD, 8'h60 | l[2:0]);
            request_inputs_i <= r[7:0];
            ack(win(r[7:0], l[2:0]), w[1:0]);
            wr(`PIMT_ADDR_CMD, 8'h30 | win(r[7:0], l[2:0]));
            request_inputs_i <= 8'h00;
        end
        $display("test random priority done");
        close_out;
    end
endmodule // pimt_core_tb
